// >>> abo_defs.svh
// constants of the address offset block: offsets, fields, reset values, bands
`ifndef ABO_DEFS_SVH
`define ABO_DEFS_SVH

// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define ABO_OFS_CFG 8'h2b
`define ABO_OFS_I2C_BASE 8'h32
`define ABO_OFS_VID_BASE 8'h33
`define ABO_OFS_READBACK 8'hdb

// ---------------------------------------------------------------
// field positions and widths
// ---------------------------------------------------------------
`define ABO_CFG_EN_BIT 0
`define ABO_CFG_I2C_BIT 1
`define ABO_CFG_VID_BIT 2
`define ABO_CFG_W 3
`define ABO_I2C_W 7
`define ABO_VID_W 4
`define ABO_OFF_W 4
`define ABO_KOHM_W 8

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define ABO_CFG_RST 3'h7
`define ABO_I2C_RST 7'h44
// vid base default not given: neutral value
`define ABO_VID_RST 4'h0

// ---------------------------------------------------------------
// valid i2c base range
// ---------------------------------------------------------------
`define ABO_I2C_MIN 7'h08
`define ABO_I2C_MAX 7'h77

// ---------------------------------------------------------------
// user power setting byte fields
// ---------------------------------------------------------------
`define ABO_UP_ENABLE_BIT 0
`define ABO_UP_RESTART_BIT 1
`define ABO_UP_RESET_MEM_BIT 3

// ---------------------------------------------------------------
// strap decode bands, in kilohm and 20 kilohm steps
// ---------------------------------------------------------------
`define ABO_STEP_KOHM 20
`define ABO_STEP_COUNT 8
`define ABO_HIGH_WEIGHT 4'h8
`define ABO_HIGH_FIRST_STEP 4'h4
`define ABO_HIGH_LAST_STEP 4'h7
`define ABO_LOW_LAST_STEP 4'h7

`endif

// >>> abo_pkg.sv
// types of the address offset block
package abo_pkg;

   typedef enum logic [1:0] {
      ABO_LATCH_WAIT = 2'b00,
      ABO_LATCH_HOLD = 2'b01
   } abo_latch_e;

   typedef logic [3:0] abo_offset_t;

endpackage

// >>> abo_strap_decode.sv
// strap resistance to offset contribution decoder for one strap pin
`timescale 1ns/1ps
`default_nettype none
`include "abo_defs.svh"

module abo_strap_decode #(
   parameter bit HIGH_WEIGHT = 1'b0
) (
   input wire logic [`ABO_KOHM_W-1:0] kohm,
   output logic [3:0] contrib
);

   logic [`ABO_STEP_COUNT-1:0] above;
   logic [3:0] step;

   // ---------------------------------------------------------------
   // round to nearest 20k step; thresholds sit halfway between bands
   // ---------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 1; gi <= `ABO_STEP_COUNT; gi++) begin : g_th
         localparam logic [`ABO_KOHM_W-1:0] TH =
            `ABO_KOHM_W'(`ABO_STEP_KOHM * gi - `ABO_STEP_KOHM / 2);
         assign above[gi-1] = (kohm >= TH); // RULE_09 RULE_18
      end
   endgenerate

   always_comb begin
      step = 4'h0;
      for (int i = 0; i < `ABO_STEP_COUNT; i++) begin
         step = step + 4'(above[i]);
      end
   end

   // ---------------------------------------------------------------
   // band to contribution; open strap (step 8) always gives zero
   // ---------------------------------------------------------------
   always_comb begin
      if (HIGH_WEIGHT) begin
         if (step >= `ABO_HIGH_FIRST_STEP && step <= `ABO_HIGH_LAST_STEP) begin
            contrib = `ABO_HIGH_WEIGHT; // RULE_10
         end else begin
            contrib = 4'h0; // RULE_10
         end
      end else begin
         if (step <= `ABO_LOW_LAST_STEP) begin
            contrib = step; // RULE_11
         end else begin
            contrib = 4'h0; // RULE_11
         end
      end
   end

endmodule
`default_nettype wire

// >>> abo_addr_sum.sv
// base address plus offset with wrap-around at the bus width
`timescale 1ns/1ps
`default_nettype none

module abo_addr_sum #(
   parameter int W = 7
) (
   input wire logic [W-1:0] base,
   input wire logic [3:0] offset,
   input wire logic apply,
   output logic [W-1:0] addr
);

   logic [W-1:0] off_ext;

   // width-limited add drops the carry: address wraps, never saturates
   always_comb begin
      off_ext = apply ? W'(offset) : '0; // RULE_07
      addr = base + off_ext; // RULE_08
   end

endmodule
`default_nettype wire

// >>> abo_top.sv
// address offset logic: strap latch, config registers, effective addresses
//
// Function
// RULE_01 - one offset 0..15 is derived and may add to both bus addresses
// RULE_02 - config bit 2 applies the offset to the vid bus address, default on
// RULE_03 - config bit 1 applies the offset to the i2c address, default on
// RULE_04 - config bit 0 enables the whole function, default on; zero disables
// RULE_05 - seven-bit i2c base register, default 44h; 8..119 valid
// RULE_06 - when enabled, both straps are sensed at power-up to find the offset
// RULE_07 - offset added where apply flag set; otherwise base address used
// RULE_08 - base plus offset wraps around past the bus maximum
// RULE_09 - straps decoded in 20k steps; shorted and open both give zero
// RULE_10 - high strap gives +8 for 80..140k, zero otherwise
// RULE_11 - low strap gives one per 20k step up to +7, zero when open
// RULE_12 - total offset is the sum of both strap contributions
// RULE_13 - offset latched once during power-up initialization, then held
// RULE_14 - virtual enable or disable alone never resamples the straps
// RULE_15 - relatch only after real power cycle or power command with mem reset
// RULE_16 - read-only register returns latched offset in its low four bits
// RULE_17 - host sets setting bit 3 to force reinitialization on leaving disable
// RULE_18 - measurements between bands snap to the nearest band
`timescale 1ns/1ps
`default_nettype none
`include "abo_defs.svh"

module abo_top (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic clk_en,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr_en,
   input wire logic reg_rd_en,
   output logic [7:0] reg_rdata,
   output logic reg_rd_valid,
   input wire logic [`ABO_KOHM_W-1:0] strap_high_kohm,
   input wire logic [`ABO_KOHM_W-1:0] strap_low_kohm,
   input wire logic strap_meas_valid,
   input wire logic user_power_wr,
   input wire logic [7:0] user_power_setting,
   output logic [`ABO_I2C_W-1:0] i2c_addr_eff,
   output logic [`ABO_VID_W-1:0] vid_addr_eff,
   output logic offset_latched,
   output logic i2c_base_invalid
);

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   abo_pkg::abo_latch_e latch_st_q, latch_st_d;
   abo_pkg::abo_offset_t offset_q, offset_d;
   logic [`ABO_CFG_W-1:0] cfg_q, cfg_d;
   logic [`ABO_I2C_W-1:0] i2c_base_q, i2c_base_d;
   logic [`ABO_VID_W-1:0] vid_base_q, vid_base_d;
   logic [7:0] rdata_q, rdata_d;
   logic rd_valid_q, rd_valid_d;
   logic [`ABO_I2C_W-1:0] i2c_eff_q, i2c_eff_d;
   logic [`ABO_VID_W-1:0] vid_eff_q, vid_eff_d;
   logic invalid_q, invalid_d;
   logic latched_q, latched_d;

   logic [3:0] high_contrib;
   logic [3:0] low_contrib;
   logic [3:0] strap_sum;
   logic mem_reset_cmd;
   logic en_eff;

   // ---------------------------------------------------------------
   // strap decode
   // ---------------------------------------------------------------
   abo_strap_decode #(
      .HIGH_WEIGHT(1'b1)
   ) u_dec_high (
      .kohm(strap_high_kohm),
      .contrib(high_contrib)
   );

   abo_strap_decode #(
      .HIGH_WEIGHT(1'b0)
   ) u_dec_low (
      .kohm(strap_low_kohm),
      .contrib(low_contrib)
   );

   // 8 + 7 at most: the 4-bit sum cannot overflow
   assign strap_sum = high_contrib + low_contrib; // RULE_12 RULE_01

   // only a power command leaving disable with mem reset reinitializes
   assign mem_reset_cmd = user_power_wr
      && user_power_setting[`ABO_UP_RESET_MEM_BIT]
      && (user_power_setting[`ABO_UP_ENABLE_BIT]
         || user_power_setting[`ABO_UP_RESTART_BIT]); // RULE_15 RULE_17

   // ---------------------------------------------------------------
   // latch sequence and register file
   // ---------------------------------------------------------------
   always_comb begin
      latch_st_d = latch_st_q;
      offset_d = offset_q;
      cfg_d = cfg_q;
      i2c_base_d = i2c_base_q;
      vid_base_d = vid_base_q;
      case (latch_st_q)
         abo_pkg::ABO_LATCH_WAIT: begin
            if (strap_meas_valid) begin
               // disabled function skips sensing and latches zero
               offset_d = cfg_q[`ABO_CFG_EN_BIT] ? strap_sum : 4'h0; // RULE_06
               latch_st_d = abo_pkg::ABO_LATCH_HOLD; // RULE_13
            end
         end
         abo_pkg::ABO_LATCH_HOLD: begin
            latch_st_d = abo_pkg::ABO_LATCH_HOLD; // RULE_13 RULE_14
         end
         default: begin
            latch_st_d = abo_pkg::ABO_LATCH_WAIT;
         end
      endcase
      if (reg_wr_en) begin
         case (reg_addr)
            `ABO_OFS_CFG: begin
               cfg_d = reg_wdata[`ABO_CFG_W-1:0]; // RULE_02 RULE_03 RULE_04
            end
            `ABO_OFS_I2C_BASE: begin
               i2c_base_d = reg_wdata[`ABO_I2C_W-1:0]; // RULE_05
            end
            `ABO_OFS_VID_BASE: begin
               vid_base_d = reg_wdata[`ABO_VID_W-1:0];
            end
            default: begin
               cfg_d = cfg_d;
            end
         endcase
      end
      // power-on defaults win over a same-cycle register write
      if (mem_reset_cmd) begin
         cfg_d = `ABO_CFG_RST;
         i2c_base_d = `ABO_I2C_RST;
         vid_base_d = `ABO_VID_RST;
         latch_st_d = abo_pkg::ABO_LATCH_WAIT; // RULE_15
      end

      // flag kept in its own flop so the port never carries a state decode
      latched_d = (latch_st_d == abo_pkg::ABO_LATCH_HOLD); // RULE_13
   end

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         latch_st_q <= abo_pkg::ABO_LATCH_WAIT;
         latched_q <= 1'b0;
         offset_q <= 4'h0;
         cfg_q <= `ABO_CFG_RST;
         i2c_base_q <= `ABO_I2C_RST;
         vid_base_q <= `ABO_VID_RST;
      end else if (clk_en) begin
         latch_st_q <= latch_st_d;
         latched_q <= latched_d;
         offset_q <= offset_d;
         cfg_q <= cfg_d;
         i2c_base_q <= i2c_base_d;
         vid_base_q <= vid_base_d;
      end
   end

   // ---------------------------------------------------------------
   // effective addresses and readback
   // ---------------------------------------------------------------
   assign en_eff = cfg_q[`ABO_CFG_EN_BIT]; // RULE_04

   abo_addr_sum #(
      .W(`ABO_I2C_W)
   ) u_sum_i2c (
      .base(i2c_base_q),
      .offset(offset_q),
      .apply(en_eff && cfg_q[`ABO_CFG_I2C_BIT]), // RULE_03
      .addr(i2c_eff_d)
   );

   abo_addr_sum #(
      .W(`ABO_VID_W)
   ) u_sum_vid (
      .base(vid_base_q),
      .offset(offset_q),
      .apply(en_eff && cfg_q[`ABO_CFG_VID_BIT]), // RULE_02
      .addr(vid_eff_d)
   );

   always_comb begin
      rd_valid_d = reg_rd_en;
      invalid_d = (i2c_base_q < `ABO_I2C_MIN) || (i2c_base_q > `ABO_I2C_MAX); // RULE_05
      case (reg_addr)
         `ABO_OFS_CFG: rdata_d = {5'h00, cfg_q};
         `ABO_OFS_I2C_BASE: rdata_d = {1'b0, i2c_base_q};
         `ABO_OFS_VID_BASE: rdata_d = {4'h0, vid_base_q};
         `ABO_OFS_READBACK: rdata_d = {4'h0, offset_q}; // RULE_16
         default: rdata_d = 8'h00;
      endcase
      if (!reg_rd_en) begin
         rdata_d = rdata_q;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         rdata_q <= 8'h00;
         rd_valid_q <= 1'b0;
         i2c_eff_q <= `ABO_I2C_RST;
         vid_eff_q <= `ABO_VID_RST;
         invalid_q <= 1'b0;
      end else if (clk_en) begin
         rdata_q <= rdata_d;
         rd_valid_q <= rd_valid_d;
         i2c_eff_q <= i2c_eff_d;
         vid_eff_q <= vid_eff_d;
         invalid_q <= invalid_d;
      end
   end

   assign reg_rdata = rdata_q;
   assign reg_rd_valid = rd_valid_q;
   assign i2c_addr_eff = i2c_eff_q;
   assign vid_addr_eff = vid_eff_q;
   assign offset_latched = latched_q;
   assign i2c_base_invalid = invalid_q;

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!reset_n);

   a_i2c_eff_sum: assert property (clk_en |=> i2c_addr_eff == // RULE_03
      `ABO_I2C_W'($past(i2c_base_q) + (($past(cfg_q) == 3'h3 || $past(cfg_q) == 3'h7)
      ? `ABO_I2C_W'($past(offset_q)) : `ABO_I2C_W'(0))))
      else $error("i2c effective address wrong");

   a_vid_eff_sum: assert property (clk_en |=> vid_addr_eff == // RULE_02
      `ABO_VID_W'($past(vid_base_q) + (($past(cfg_q) == 3'h5 || $past(cfg_q) == 3'h7)
      ? $past(offset_q) : 4'h0)))
      else $error("vid effective address wrong");

   a_disable_base: assert property (clk_en && !cfg_q[0] |=> // RULE_04
      i2c_addr_eff == $past(i2c_base_q) && vid_addr_eff == $past(vid_base_q))
      else $error("disabled offset still applied");

   a_reset_defaults: assert property ($rose(reset_n) |-> // RULE_05
      i2c_base_q == 7'h44 && cfg_q == 3'h7 && !offset_latched)
      else $error("power-on defaults wrong");

   a_latch_value: assert property (clk_en && !offset_latched && strap_meas_valid // RULE_12
      && !mem_reset_cmd && cfg_q[0] |=> offset_latched
      && offset_q == $past(high_contrib) + $past(low_contrib))
      else $error("latched offset is not strap sum");

   a_latch_disabled: assert property (clk_en && !offset_latched && strap_meas_valid // RULE_06
      && !cfg_q[0] |=> offset_q == 4'h0)
      else $error("disabled function latched a nonzero offset");

   a_offset_hold: assert property (offset_latched && !mem_reset_cmd |=> // RULE_13
      $stable(offset_q) && offset_latched)
      else $error("latched offset changed");

   a_plain_power_cmd: assert property (offset_latched && user_power_wr // RULE_14
      && !user_power_setting[3] |=> offset_latched && $stable(offset_q))
      else $error("virtual enable relatched the offset");

   a_mem_reset_relatch: assert property (clk_en && mem_reset_cmd |=> // RULE_15
      !offset_latched && i2c_base_q == 7'h44)
      else $error("mem reset did not restart latch");

   a_readback_value: assert property (clk_en && reg_rd_en && reg_addr == 8'hdb |=> // RULE_16
      reg_rd_valid && reg_rdata == {4'h0, $past(offset_q)})
      else $error("offset readback wrong");

   a_rd_pulse: assert property (clk_en && !reg_rd_en |=> // RULE_16
      !reg_rd_valid && $stable(reg_rdata))
      else $error("read answer without a read strobe");

   a_cfg_write: assert property (clk_en && reg_wr_en && reg_addr == 8'h2b // RULE_04
      && !mem_reset_cmd |=> cfg_q == 3'($past(reg_wdata)))
      else $error("config write not taken");

   a_invalid_flag: assert property (clk_en |=> i2c_base_invalid == // RULE_05
      ($past(i2c_base_q) < 7'h08 || $past(i2c_base_q) > 7'h77))
      else $error("i2c base range flag wrong");

   a_high_band: assert property (strap_high_kohm >= 8'd80 && strap_high_kohm <= 8'd140 // RULE_10
      |-> high_contrib == 4'h8)
      else $error("high strap band decode wrong");

   a_low_open: assert property (strap_low_kohm >= 8'd170 |-> low_contrib == 4'h0 // RULE_09 RULE_11
      && (strap_high_kohm < 8'd170 || strap_sum == 4'h0))
      else $error("open strap not zero");

   c_latch_nonzero: cover property (clk_en && !offset_latched && strap_meas_valid
      ##1 offset_q == 4'hf);
   c_i2c_wrap: cover property (clk_en && i2c_base_q == 7'h77 && offset_q != 4'h0
      && cfg_q == 3'h7);
   c_mem_reset: cover property (offset_latched && mem_reset_cmd && clk_en);
   c_readback: cover property (reg_rd_valid && reg_rdata != 8'h00);

endmodule
`default_nettype wire

// >>> abo_strap_model.sv
// strap measurement front end model: readings settle a while after each power-up
`timescale 1ns/1ps
`default_nettype none

module abo_strap_model (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic [7:0] settle,
   input wire logic [7:0] hi_target,
   input wire logic [7:0] lo_target,
   input wire logic user_power_wr,
   input wire logic [7:0] user_power_setting,
   output logic [7:0] strap_high_kohm,
   output logic [7:0] strap_low_kohm,
   output logic strap_meas_valid
);
   logic [7:0] cnt_q;
   logic [7:0] cnt_d;
   logic restart;

   // a re-init request restarts the measurement like a real power-up
   assign restart = user_power_wr && user_power_setting[3] &&
                    (user_power_setting[0] || user_power_setting[1]);

   always_comb begin
      cnt_d = cnt_q;
      if (restart) begin
         cnt_d = 8'h00;
      end else if (cnt_q != settle) begin
         cnt_d = cnt_q + 8'h01;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         cnt_q <= 8'h00;
      end else begin
         cnt_q <= cnt_d;
      end
   end

   // unsettled readings are garbage, never the final value
   assign strap_meas_valid = (cnt_q == settle) && reset_n;
   assign strap_high_kohm = strap_meas_valid ? hi_target : ~hi_target;
   assign strap_low_kohm = strap_meas_valid ? lo_target : ~lo_target;
endmodule
`default_nettype wire

// >>> tb.sv
// testbench of the address offset block: registers, strap latch, power commands
`timescale 1ns/1ps
`default_nettype none

module tb;
   logic clk_sys = 1'b0;
   logic reset_n = 1'b0;
   logic clk_en = 1'b1;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr_en = 1'b0;
   logic reg_rd_en = 1'b0;
   logic [7:0] reg_rdata;
   logic reg_rd_valid;
   logic [7:0] strap_high_kohm;
   logic [7:0] strap_low_kohm;
   logic strap_meas_valid;
   logic user_power_wr = 1'b0;
   logic [7:0] user_power_setting = 8'h00;
   logic [6:0] i2c_addr_eff;
   logic [3:0] vid_addr_eff;
   logic offset_latched;
   logic i2c_base_invalid;
   logic [7:0] settle = 8'h05;
   logic [7:0] hi_t = 8'h00;
   logic [7:0] lo_t = 8'h00;
   int errors = 0;
   int checks_done = 0;
   // high kohm, low kohm, expected offset; in-between values snap, ties go up
   logic [7:0] tab [0:7][0:2] = '{'{8'd0, 8'd0, 8'd0}, '{8'd145, 8'd10, 8'd9},
      '{8'd80, 8'd20, 8'd9}, '{8'd60, 8'd60, 8'd3}, '{8'd100, 8'd35, 8'd10},
      '{8'd70, 8'd70, 8'd12}, '{8'd160, 8'd150, 8'd0}, '{8'd140, 8'd140, 8'd15}};
   logic [7:0] ign [0:3] = '{8'h00, 8'h01, 8'h06, 8'h08};

   abo_top u_dut (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .clk_en(clk_en),
      .reg_addr(reg_addr),
      .reg_wdata(reg_wdata),
      .reg_wr_en(reg_wr_en),
      .reg_rd_en(reg_rd_en),
      .reg_rdata(reg_rdata),
      .reg_rd_valid(reg_rd_valid),
      .strap_high_kohm(strap_high_kohm),
      .strap_low_kohm(strap_low_kohm),
      .strap_meas_valid(strap_meas_valid),
      .user_power_wr(user_power_wr),
      .user_power_setting(user_power_setting),
      .i2c_addr_eff(i2c_addr_eff),
      .vid_addr_eff(vid_addr_eff),
      .offset_latched(offset_latched),
      .i2c_base_invalid(i2c_base_invalid)
   );

   abo_strap_model u_strap (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .settle(settle),
      .hi_target(hi_t),
      .lo_target(lo_t),
      .user_power_wr(user_power_wr),
      .user_power_setting(user_power_setting),
      .strap_high_kohm(strap_high_kohm),
      .strap_low_kohm(strap_low_kohm),
      .strap_meas_valid(strap_meas_valid)
   );

   initial begin
      forever #5 clk_sys = ~clk_sys;
   end

   // ---------------------------------------------------------------
   // access tasks
   // ---------------------------------------------------------------
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      checks_done++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr_en <= 1'b1;
      @(posedge clk_sys);
      reg_wr_en <= 1'b0;
      repeat (2) @(posedge clk_sys);
      #1;
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd_en <= 1'b1;
      @(posedge clk_sys);
      reg_rd_en <= 1'b0;
      #1;
      chk({7'h00, reg_rd_valid}, 8'h01, "rd valid");
      chk(reg_rdata, exp, "rd data");
   endtask

   task automatic chk_addr(input logic [6:0] i2c, input logic [3:0] vid);
      chk({1'b0, i2c_addr_eff}, {1'b0, i2c}, "i2c addr");
      chk({4'h0, vid_addr_eff}, {4'h0, vid}, "vid addr");
   endtask

   // bounded wait, so a latch that never comes shows up as a mismatch
   task automatic wait_latch();
      int n;
      n = 0;
      #1;
      while (offset_latched !== 1'b1 && n < 300) begin
         @(posedge clk_sys);
         #1;
         n++;
      end
      repeat (3) @(posedge clk_sys);
      #1;
      chk({7'h00, offset_latched}, 8'h01, "latched");
   endtask

   task automatic pwr(input logic [7:0] s);
      @(posedge clk_sys);
      user_power_wr <= 1'b1;
      user_power_setting <= s;
      @(posedge clk_sys);
      user_power_wr <= 1'b0;
      wait_latch();
   endtask

   task automatic end_of_test();
      $display("errors %0d checks_done %0d", errors, checks_done);
      if (errors == 0 && checks_done > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // ---------------------------------------------------------------
   // tests
   // ---------------------------------------------------------------
   initial begin
      repeat (16) @(posedge clk_sys);
      reset_n <= 1'b1;
      #1;
      chk({7'h00, offset_latched}, 8'h00, "latched early");
      rd(8'h2b, 8'h07);
      rd(8'h32, 8'h44);
      rd(8'h33, 8'h00);
      wait_latch();
      rd(8'hdb, 8'h00);
      for (int i = 0; i < 8; i++) begin
         hi_t <= tab[i][0];
         lo_t <= tab[i][1];
         settle <= (i % 2 == 1) ? 8'h00 : 8'h20;
         pwr(8'h1a);
         rd(8'hdb, tab[i][2]);
         chk_addr(7'h44 + tab[i][2][6:0], tab[i][2][3:0]);
      end
      hi_t <= 8'd0;
      lo_t <= 8'd0;
      for (int i = 0; i < 4; i++) begin
         pwr(ign[i]);
         rd(8'hdb, 8'h0f);
      end
      wr(8'h32, 8'h77);
      wr(8'h33, 8'h0f);
      chk_addr(7'h06, 4'he);
      chk({7'h00, i2c_base_invalid}, 8'h00, "base 77 valid");
      wr(8'h32, 8'h78);
      chk({7'h00, i2c_base_invalid}, 8'h01, "base 78 invalid");
      wr(8'h32, 8'h07);
      chk({7'h00, i2c_base_invalid}, 8'h01, "base 07 invalid");
      wr(8'h32, 8'h08);
      chk({7'h00, i2c_base_invalid}, 8'h00, "base 08 valid");
      wr(8'h32, 8'h77);
      wr(8'h2b, 8'h05);
      chk_addr(7'h77, 4'he);
      rd(8'h2b, 8'h05);
      wr(8'h2b, 8'h03);
      chk_addr(7'h06, 4'hf);
      wr(8'h2b, 8'h06);
      chk_addr(7'h77, 4'hf);
      rd(8'hdb, 8'h0f);
      wr(8'h2b, 8'hff);
      rd(8'h2b, 8'h07);
      wr(8'hdb, 8'h00);
      rd(8'hdb, 8'h0f);
      wr(8'h10, 8'hab);
      rd(8'h10, 8'h00);
      // frozen clock enable: a write must not land and outputs must hold
      @(posedge clk_sys);
      clk_en <= 1'b0;
      wr(8'h2b, 8'h00);
      chk_addr(7'h06, 4'he);
      @(posedge clk_sys);
      clk_en <= 1'b1;
      rd(8'h2b, 8'h07);
      // real power cycle in mid-run
      hi_t <= 8'd80;
      lo_t <= 8'd20;
      @(posedge clk_sys);
      reset_n <= 1'b0;
      repeat (2) @(posedge clk_sys);
      reset_n <= 1'b1;
      wait_latch();
      rd(8'hdb, 8'h09);
      rd(8'h32, 8'h44);
      chk_addr(7'h4d, 4'h9);
      end_of_test();
   end

   initial begin
      #200000;
      errors++;
      end_of_test();
   end
endmodule
`default_nettype wire
